// ===== dv/csi2_video_output_ctrl_bench.sv
// Self-checking bench for cvo_top: registers, framing, resets.
// Assumes one data lane and straight lane mapping from reset.
`timescale 1ns/1ps
`default_nettype none
module csi2_video_output_ctrl_bench;
  logic ref_clk_i = 1'b0, link_clk_i = 1'b0, rst_b_i = 1'b0, reg_page_i = 1'b0;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, vid_sof_i = 1'b0, vid_eof_i = 1'b0;
  logic vid_valid_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, vid_data_i = 8'h00;
  logic [1:0] vc_id_i = 2'h2;
  wire logic [7:0] reg_rdata_o;
  wire logic vid_ready_o, phy_bias_en_o, phy_clk_invert_o;
  wire logic [4:0] lane_clk_mode_en_o, lane_hs_o;
  wire logic [4:0][7:0] lane_data_o;
  int err_total = 0, n_checks = 0, cyc = 0;
  localparam logic [16:0] RT [16] = '{17'h00400, 17'h00640, 17'h00704, 17'h02100,
    17'h06c0f, 17'h06d00, 17'h07001, 17'h07100, 17'h07880, 17'h07902, 17'h01000,
    17'h10002, 17'h10210, 17'h10410, 17'h10532, 17'h10604};
  localparam int EP [8] = '{0, 1, 4, 5, 8, 15, 18, 19};
  localparam logic [7:0] EV [8] = '{8'h80, 8'h01, 8'h9e, 8'h08, 8'h10, 8'h17, 8'h81, 8'h01};
  always #20 ref_clk_i = ~ref_clk_i;
  always #3 link_clk_i = ~link_clk_i;
  cvo_top dut_u (
    .ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i), .rst_b_i(rst_b_i),
    .reg_page_i(reg_page_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .vc_id_i(vc_id_i), .vid_sof_i(vid_sof_i), .vid_eof_i(vid_eof_i),
    .vid_valid_i(vid_valid_i), .vid_data_i(vid_data_i), .vid_ready_o(vid_ready_o),
    .phy_bias_en_o(phy_bias_en_o), .phy_clk_invert_o(phy_clk_invert_o),
    .lane_clk_mode_en_o(lane_clk_mode_en_o), .lane_data_o(lane_data_o),
    .lane_hs_o(lane_hs_o));
  cvo_rx_model rx_u (.link_clk_i(link_clk_i), .lane_data_i(lane_data_o),
    .lane_hs_i(lane_hs_o));
  // ==========
  // Access tasks
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic pg, input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    {reg_wr_i, reg_rd_i, reg_page_i, reg_addr_i, reg_wdata_i} <= {w, !w, pg, a, d};
    @(posedge ref_clk_i);
    {reg_wr_i, reg_rd_i} <= 2'b00;
    @(negedge ref_clk_i);
    if (!w) chk($sformatf("reg %0d:%h", pg, a), reg_rdata_o, d);
  endtask
  task automatic vbyte(input logic [7:0] d);
    int i;
    @(posedge ref_clk_i);
    {vid_valid_i, vid_data_i} <= {1'b1, d};
    i = 0;
    do begin @(negedge ref_clk_i); i++; end while (vid_ready_o !== 1'b1 && i < 500);
    chk("vid ready", {7'h00, vid_ready_o}, 8'h01);
    @(posedge ref_clk_i);
    vid_valid_i <= 1'b0;
  endtask
  task automatic pls(input logic s);
    @(posedge ref_clk_i);
    {vid_sof_i, vid_eof_i} <= {s, !s};
    @(posedge ref_clk_i);
    {vid_sof_i, vid_eof_i} <= 2'b00;
    repeat (200) @(posedge ref_clk_i);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Whole run is under two thousand cycles; the ceiling only catches hangs
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      print_verdict();
    end
  end
  // ==========
  // Tests
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    foreach (RT[k]) acc(1'b0, RT[k][16], RT[k][15:8], RT[k][7:0]);
    $display("test reset_values done");
    acc(1'b1, 1'b1, 8'h00, 8'h07);
    acc(1'b1, 1'b1, 8'h02, 8'h1f);
    chk("phy ctl", {6'h00, phy_clk_invert_o, phy_bias_en_o}, 8'h03);
    acc(1'b0, 1'b1, 8'h02, 8'h1f);
    acc(1'b1, 1'b0, 8'h71, 8'ha5);
    acc(1'b0, 1'b0, 8'h71, 8'ha5);
    acc(1'b1, 1'b0, 8'h71, 8'h00);
    $display("test reg_write done");
    acc(1'b1, 1'b0, 8'h21, 8'h01);
    repeat (10) @(posedge ref_clk_i);
    chk("ck hs on", {7'h00, lane_hs_o[4]}, 8'h01);
    acc(1'b1, 1'b0, 8'h07, 8'h05);
    repeat (10) @(posedge ref_clk_i);
    chk("ck lp idle", {7'h00, lane_hs_o[4]}, 8'h00);
    $display("test clock_lane done");
    acc(1'b1, 1'b0, 8'h78, 8'h02);
    acc(1'b1, 1'b0, 8'h79, 8'h00);
    pls(1'b1);
    for (int b = 0; b < 8; b++) vbyte(8'h10 + 8'(b));
    repeat (200) @(posedge ref_clk_i);
    pls(1'b0);
    foreach (EP[k]) chk($sformatf("rx %0d", EP[k]), rx_u.rx_q[EP[k]], EV[k]);
    chk("rx len", 8'(rx_u.rx_q.size()), 8'h16);
    $display("test frame done");
    acc(1'b1, 1'b0, 8'h04, 8'h01);
    vbyte(8'h55);
    @(negedge ref_clk_i);
    chk("ready held", {7'h00, vid_ready_o}, 8'h01);
    acc(1'b1, 1'b0, 8'h04, 8'h00);
    repeat (200) @(posedge ref_clk_i);
    chk("rx len held", 8'(rx_u.rx_q.size()), 8'h16);
    acc(1'b1, 1'b0, 8'h07, 8'h04);
    acc(1'b1, 1'b0, 8'h04, 8'h02);
    repeat (10) @(posedge ref_clk_i);
    chk("phy rst lanes", {3'h0, lane_hs_o}, 8'h00);
    acc(1'b1, 1'b0, 8'h04, 8'h00);
    repeat (10) @(posedge ref_clk_i);
    chk("phy released", {7'h00, lane_hs_o[4]}, 8'h01);
    $display("test resets done");
    acc(1'b1, 1'b0, 8'h6d, 8'h01);
    pls(1'b1);
    chk("fs zero di", rx_u.rx_q[22], 8'h80);
    chk("fs zero num", rx_u.rx_q[23], 8'h00);
    acc(1'b0, 1'b0, 8'h72, 8'h00);
    acc(1'b1, 1'b0, 8'h06, 8'h48);
    pls(1'b1);
    chk("two lane len", 8'(rx_u.rx_q.size()), 8'h1c);
    $display("test modes done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ===== dv/cvo_monitor.sv
// Checker bound to cvo_top: register side effects and lane gating.
// Assumes sampling on ref_clk_i; lane outputs cross from the link clock.
`timescale 1ns/1ps
`default_nettype none
module cvo_monitor (
  // Clock, reset, register writes
  input wire logic       ref_clk_i,
  input wire logic       rst_b_i,
  input wire logic       reg_page_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  // Watched signals
  input wire logic       vid_valid_i,
  input wire logic       vid_ready_o,
  input wire logic       phy_bias_en_o,
  input wire logic       phy_clk_invert_o,
  input wire logic [4:0] lane_clk_mode_en_o,
  input wire logic [4:0] lane_hs_o
);
  // ==========
  // Shadow copies of controller-page bits
  logic       hs_r, nc_r;
  logic [1:0] sr_r;
  logic [3:0] nl_r;
  wire        w0 = reg_wr_i && !reg_page_i;
  wire        w1 = reg_wr_i && reg_page_i;
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {hs_r, nc_r, sr_r, nl_r} <= 8'h00;
    end else if (w0) begin
      if (reg_addr_i == 8'h21) hs_r <= reg_wdata_i[0];
      if (reg_addr_i == 8'h07) nc_r <= reg_wdata_i[0];
      if (reg_addr_i == 8'h04) sr_r <= reg_wdata_i[1:0];
      if (reg_addr_i == 8'h06) nl_r <= reg_wdata_i[5:2];
    end
  end
  // ==========
  // Waits of a few cycles allow for the crossing from the link domain
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);
  a_hs_gated: assert property ((!hs_r)[*4] |-> !lane_hs_o[4])
    else $error("clock lane fast while off");
  a_hs_cont: assert property ((hs_r && !nc_r && !sr_r[1])[*4] |-> lane_hs_o[4])
    else $error("clock lane not continuous");
  a_hold_ready: assert property (sr_r[0] && $past(sr_r[0]) |-> vid_ready_o)
    else $error("held packer stalls video");
  a_hold_quiet: assert property (sr_r[0][*8] |-> lane_hs_o[3:0] == 4'h0)
    else $error("held packer sends");
  a_phy_quiet: assert property (sr_r[1][*4] |-> lane_hs_o == 5'h00)
    else $error("lanes active in phy reset");
  a_bias_write: assert property (w1 && reg_addr_i == 8'h00 |=>
    {phy_clk_invert_o, phy_bias_en_o} == {$past(reg_wdata_i[2]), $past(reg_wdata_i[0])})
    else $error("phy control bits wrong");
  a_ckm_write: assert property (w1 && reg_addr_i == 8'h02 |=>
    lane_clk_mode_en_o == $past(reg_wdata_i[4:0]))
    else $error("clock mode enables wrong");
  a_lane_cnt: assert property ((nl_r < 4'h2)[*8] |-> lane_hs_o[3:1] == 3'h0)
    else $error("extra data lane active");
  c_byte: cover property (vid_valid_i && vid_ready_o);
  c_data: cover property (lane_hs_o[0]);
  c_clk: cover property (lane_hs_o[4] && hs_r);
endmodule
bind cvo_top cvo_monitor mon_u (
  .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .reg_page_i(reg_page_i),
  .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .vid_valid_i(vid_valid_i), .vid_ready_o(vid_ready_o), .phy_bias_en_o(phy_bias_en_o),
  .phy_clk_invert_o(phy_clk_invert_o), .lane_clk_mode_en_o(lane_clk_mode_en_o),
  .lane_hs_o(lane_hs_o));
`default_nettype wire

// ===== dv/cvo_rx_model.sv
// Receiver model at the lane side of cvo_top.
// Assumes one active data lane; logs each strobed byte of lane 0.
`timescale 1ns/1ps
`default_nettype none
module cvo_rx_model (
  // Link clock and lanes
  input wire logic            link_clk_i,
  input wire logic [4:0][7:0] lane_data_i,
  input wire logic [4:0]      lane_hs_i
);
  logic [7:0] rx_q[$];
  // One byte per strobe at the fixed rate; nothing is negotiated
  always @(posedge link_clk_i) begin
    if (lane_hs_i[0] === 1'b1) begin
      rx_q.push_back(lane_data_i[0]);
    end
  end
endmodule
`default_nettype wire

// ===== verilog/cvo_lane_tx.sv
// Link-domain lane driver: spreads packet bytes over the active lanes.
// Assumes byte data stays stable from a request toggle until its acknowledge.
`timescale 1ns/1ps
`default_nettype none
module cvo_lane_tx (
  // Clock and reset
  input  wire logic                 link_clk_i,
  input  wire logic                 rst_b_i,
  // From the packer
  cvo_link_if.sink                  lk,
  // Physical lanes
  output logic [4:0][7:0]           lane_data_o,
  output logic [4:0]                lane_hs_o
);
  typedef struct packed {
    logic [1:0]      req_s;
    logic            seen;
    logic [20:0]     cfg_s1;
    logic [20:0]     cfg_s2;
    logic [1:0]      cnt;
    logic            in_pkt;
    logic [4:0][7:0] data;
    logic [4:0]      hs;
  } cvo_lane_type;

  localparam int NLANE_C = cvo_pkg::NLANE;

  cvo_lane_type s_r;
  cvo_lane_type s_nxt;
  logic [4:0][2:0] sel;
  logic [2:0]      lanes;
  logic            hs_en;
  logic            ncont;
  logic            phy_rst;
  logic            newb;
  logic [1:0]      idx;
  logic            clk_hs;

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.req_s = {s_r.req_s[0], lk.req};
    // Config is static in use, so a plain per-bit double flop is enough
    s_nxt.cfg_s1 = {lk.phy_rst, lk.ncont, lk.hs_en, lk.lanes, lk.sel};
    s_nxt.cfg_s2 = s_r.cfg_s1;
    {phy_rst, ncont, hs_en, lanes, sel} = s_r.cfg_s2;
    newb = (s_r.req_s[1] != s_r.seen);
    idx = lk.first ? 2'h0 : s_r.cnt;
    s_nxt.hs = '0;
    if (newb) begin
      // Acknowledge even under soft reset so the packer never hangs
      s_nxt.seen = s_r.req_s[1];
    end
    if (phy_rst) begin
      s_nxt.cnt = '0;
      s_nxt.in_pkt = 1'b0;
    end else if (newb) begin
      for (int p = 0; p < NLANE_C; p++) begin
        if (sel[p] == {1'b0, idx}) begin
          s_nxt.data[p] = lk.data;
          s_nxt.hs[p] = 1'b1;
        end
      end
      if (lk.last || ({1'b0, idx} + 3'h1 >= lanes)) begin
        s_nxt.cnt = '0;
      end else begin
        s_nxt.cnt = idx + 2'h1;
      end
      s_nxt.in_pkt = ~lk.last;
    end
    // Clock lane idles in low power outside packets in non-continuous mode
    clk_hs = ~phy_rst & hs_en & (~ncont | s_nxt.in_pkt | newb);
    for (int p = 0; p < NLANE_C; p++) begin
      if (sel[p] == cvo_pkg::SRC_CLK) begin
        s_nxt.hs[p] = clk_hs;
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign lk.ack      = s_r.seen;
  assign lane_data_o = s_r.data;
  assign lane_hs_o   = s_r.hs;
endmodule
`default_nettype wire

// ===== verilog/cvo_link_if.sv
// Carrier between the reference-domain packer and the link-domain lane driver.
// Assumes config fields are quasi-static; the far end synchronises them.
`timescale 1ns/1ps
`default_nettype none
interface cvo_link_if;
  logic                  req;
  logic                  ack;
  logic [7:0]            data;
  logic                  first;
  logic                  last;
  logic [2:0]            lanes;
  logic [4:0][2:0]       sel;
  logic                  hs_en;
  logic                  ncont;
  logic                  phy_rst;
  modport src  (output req, data, first, last, lanes, sel, hs_en, ncont, phy_rst,
                input ack);
  modport sink (input req, data, first, last, lanes, sel, hs_en, ncont, phy_rst,
                output ack);
endinterface
`default_nettype wire

// ===== verilog/cvo_pkg.sv
// Constants, register map and types of the CSI-2 video output controller.
// Assumes an 8-bit register port with a page select and a 25 MHz reference clock.
`default_nettype none
package cvo_pkg;
  // ==========================================================================
  // Register pages and offsets
  localparam logic       PAGE_CSI     = 1'b0;
  localparam logic       PAGE_TX      = 1'b1;
  localparam logic [7:0] A_RST        = 8'h04;
  localparam logic [7:0] A_LANE       = 8'h06;
  localparam logic [7:0] A_NCONT      = 8'h07;
  localparam logic [7:0] A_HSEN       = 8'h21;
  localparam logic [7:0] A_CHEN       = 8'h6c;
  localparam logic [7:0] A_FMODE      = 8'h6d;
  localparam logic [7:0] A_FMAXL      = 8'h70;
  localparam logic [7:0] A_FMAXH      = 8'h71;
  localparam logic [7:0] A_FCURL      = 8'h72;
  localparam logic [7:0] A_FCURH      = 8'h73;
  localparam logic [7:0] A_YCL        = 8'h78;
  localparam logic [7:0] A_YCH        = 8'h79;
  localparam logic [7:0] A_BIAS       = 8'h00;
  localparam logic [7:0] A_CKM        = 8'h02;
  localparam logic [7:0] A_SEL01      = 8'h04;
  localparam logic [7:0] A_SEL23      = 8'h05;
  localparam logic [7:0] A_SELC       = 8'h06;
  // ==========================================================================
  // Register indices and reset values
  localparam int         NREG         = 15;
  localparam logic [4:0] I_RST        = 5'h00;
  localparam logic [4:0] I_LANE       = 5'h01;
  localparam logic [4:0] I_NCONT      = 5'h02;
  localparam logic [4:0] I_HSEN       = 5'h03;
  localparam logic [4:0] I_CHEN       = 5'h04;
  localparam logic [4:0] I_FMODE      = 5'h05;
  localparam logic [4:0] I_FMAXL      = 5'h06;
  localparam logic [4:0] I_FMAXH      = 5'h07;
  localparam logic [4:0] I_YCL        = 5'h08;
  localparam logic [4:0] I_YCH        = 5'h09;
  localparam logic [4:0] I_BIAS       = 5'h0a;
  localparam logic [4:0] I_CKM        = 5'h0b;
  localparam logic [4:0] I_SEL01      = 5'h0c;
  localparam logic [4:0] I_SEL23      = 5'h0d;
  localparam logic [4:0] I_SELC       = 5'h0e;
  localparam logic [4:0] I_FCURL      = 5'h0f;
  localparam logic [4:0] I_FCURH      = 5'h10;
  localparam logic [4:0] I_NONE       = 5'h1f;
  localparam logic [NREG-1:0][7:0] REG_RST = {
    8'h04, 8'h32, 8'h10, 8'h10, 8'h02, 8'h02, 8'h80, 8'h00,
    8'h01, 8'h00, 8'h0f, 8'h00, 8'h04, 8'h40, 8'h00};
  // ==========================================================================
  // Field positions
  localparam int B_CTRL_RST  = 0;
  localparam int B_PHY_RST   = 1;
  localparam int B_EN0       = 0;
  localparam int B_CH_RST    = 4;
  localparam int B_BIAS      = 0;
  localparam int B_CLK_INV   = 2;
  localparam int B_NCONT     = 0;
  localparam int B_HSEN      = 0;
  localparam int LANE_LSB    = 2;
  localparam int NLANE       = 5;
  localparam logic [2:0] SRC_CLK = 3'h4;
  localparam logic [1:0] FMODE_ZERO = 2'h1;
  // ==========================================================================
  // Packet codes and link timing
  localparam logic [5:0]  DT_FS       = 6'h00;
  localparam logic [5:0]  DT_FE       = 6'h01;
  localparam logic [5:0]  DT_SHORT_MAX = 6'h0f;
  localparam logic [5:0]  DT_YUV8     = 6'h1e;
  localparam logic [15:0] CRC_INIT    = 16'hffff;
  localparam logic [15:0] CRC_POLY    = 16'h8408;
  localparam int          LINK_MBPS   = 648;
  localparam logic [5:0][23:0] ECC_MASK = {
    24'heffc00, 24'hdf03f0, 24'hb8e38e, 24'h749a6d, 24'hf2555b, 24'hf12cb7};
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_HDR  = 2'b01,
    S_PAY  = 2'b10,
    S_CRC  = 2'b11
  } cvo_state_type;
endpackage
`default_nettype wire

// ===== verilog/cvo_top.sv
// CSI-2 video output controller: register file, packet framer and lane driver.
// Assumes a decoder byte stream on ref_clk_i and a separate link byte clock.
`timescale 1ns/1ps
`default_nettype none
module cvo_top (
  // Clocks and reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 link_clk_i,
  input  wire logic                 rst_b_i,
  // Register port
  input  wire logic                 reg_page_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic                 reg_wr_i,
  input  wire logic [7:0]           reg_wdata_i,
  input  wire logic                 reg_rd_i,
  output logic [7:0]                reg_rdata_o,
  // Decoder video stream
  input  wire logic [1:0]           vc_id_i,
  input  wire logic                 vid_sof_i,
  input  wire logic                 vid_eof_i,
  input  wire logic                 vid_valid_i,
  input  wire logic [7:0]           vid_data_i,
  output logic                      vid_ready_o,
  // PHY controls
  output logic                      phy_bias_en_o,
  output logic                      phy_clk_invert_o,
  output logic [4:0]                lane_clk_mode_en_o,
  // Physical lanes
  output logic [4:0][7:0]           lane_data_o,
  output logic [4:0]                lane_hs_o
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [cvo_pkg::NREG-1:0][7:0] regs;
    logic [7:0]                    rdata;
    cvo_pkg::cvo_state_type        st;
    logic                          is_long;
    logic [1:0]                    hcnt;
    logic [11:0]                   pcnt;
    logic [15:0]                   crc;
    logic [7:0]                    di;
    logic [15:0]                   wd;
    logic [15:0]                   fnum;
    logic                          sof_pend;
    logic                          eof_pend;
    logic                          req;
    logic [1:0]                    ack_s;
    logic [7:0]                    byte_d;
    logic                          first;
    logic                          last;
  } cvo_top_type;

  cvo_top_type s_r;
  cvo_top_type s_nxt;
  cvo_link_if  lk ();

  logic [4:0]  widx;
  logic [4:0]  ridx;
  logic        tx_rdy;
  logic        hold;
  logic [15:0] fmax;
  logic [11:0] wc;
  logic [15:0] fnext;
  logic [7:0]  hb;
  logic [1:0]  fmode;

  // ==========================================================================
  // Functions
  // Map page and offset to a storage index; used by both write and read paths
  function automatic logic [4:0] reg_index(input logic page, input logic [7:0] a);
    logic [4:0] r;
    r = cvo_pkg::I_NONE;
    if (page == cvo_pkg::PAGE_CSI) begin
      case (a)
        cvo_pkg::A_RST:   r = cvo_pkg::I_RST;
        cvo_pkg::A_LANE:  r = cvo_pkg::I_LANE;
        cvo_pkg::A_NCONT: r = cvo_pkg::I_NCONT;
        cvo_pkg::A_HSEN:  r = cvo_pkg::I_HSEN;
        cvo_pkg::A_CHEN:  r = cvo_pkg::I_CHEN;
        cvo_pkg::A_FMODE: r = cvo_pkg::I_FMODE;
        cvo_pkg::A_FMAXL: r = cvo_pkg::I_FMAXL;
        cvo_pkg::A_FMAXH: r = cvo_pkg::I_FMAXH;
        cvo_pkg::A_FCURL: r = cvo_pkg::I_FCURL;
        cvo_pkg::A_FCURH: r = cvo_pkg::I_FCURH;
        cvo_pkg::A_YCL:   r = cvo_pkg::I_YCL;
        cvo_pkg::A_YCH:   r = cvo_pkg::I_YCH;
        default:          r = cvo_pkg::I_NONE;
      endcase
    end else begin
      case (a)
        cvo_pkg::A_BIAS:  r = cvo_pkg::I_BIAS;
        cvo_pkg::A_CKM:   r = cvo_pkg::I_CKM;
        cvo_pkg::A_SEL01: r = cvo_pkg::I_SEL01;
        cvo_pkg::A_SEL23: r = cvo_pkg::I_SEL23;
        cvo_pkg::A_SELC:  r = cvo_pkg::I_SELC;
        default:          r = cvo_pkg::I_NONE;
      endcase
    end
    return r;
  endfunction

  // Header error code over identifier and word count
  function automatic logic [7:0] hdr_ecc(input logic [23:0] d);
    logic [7:0] e;
    e = '0;
    for (int i = 0; i < 6; i++) begin
      e[i] = ^(d & cvo_pkg::ECC_MASK[i]);
    end
    return e;
  endfunction

  // Payload checksum, one byte at a time, least significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 8; i++) begin
      fb = r[0] ^ d[i];
      r = r >> 1;
      if (fb) begin
        r = r ^ cvo_pkg::CRC_POLY;
      end
    end
    return r;
  endfunction

  // Undefined lane counts clamp to the nearest supported one
  function automatic logic [2:0] lane_count(input logic [3:0] f);
    logic [2:0] n;
    if (f <= 4'h1) begin
      n = 3'h1;
    end else if (f >= 4'h4) begin
      n = 3'h4;
    end else begin
      n = f[2:0];
    end
    return n;
  endfunction

  // ==========================================================================
  // Decoded controls
  always_comb begin
    widx  = reg_index(reg_page_i, reg_addr_i);
    ridx  = widx;
    fmax  = {s_r.regs[cvo_pkg::I_FMAXH], s_r.regs[cvo_pkg::I_FMAXL]};
    wc    = {s_r.regs[cvo_pkg::I_YCH][1:0], s_r.regs[cvo_pkg::I_YCL], 2'b00};
    fmode = s_r.regs[cvo_pkg::I_FMODE][1:0];
    // Zero mode sends frame number zero; other modes count 1..max and wrap
    if (fmode == cvo_pkg::FMODE_ZERO) begin
      fnext = '0;
    end else if (s_r.fnum == '0 || s_r.fnum >= fmax) begin
      fnext = 16'h0001;
    end else begin
      fnext = s_r.fnum + 16'h0001;
    end
    hold = s_r.regs[cvo_pkg::I_RST][cvo_pkg::B_CTRL_RST]
         | s_r.regs[cvo_pkg::I_CHEN][cvo_pkg::B_CH_RST]
         | ~s_r.regs[cvo_pkg::I_CHEN][cvo_pkg::B_EN0];
    tx_rdy = (s_r.req == s_r.ack_s[1]);
    case (s_r.hcnt)
      2'h0:    hb = s_r.di;
      2'h1:    hb = s_r.wd[7:0];
      2'h2:    hb = s_r.wd[15:8];
      default: hb = hdr_ecc({s_r.wd, s_r.di});
    endcase
  end

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.ack_s = {s_r.ack_s[0], lk.ack};
    // A new pulse wins over the clear that takes the pending one
    s_nxt.sof_pend = s_r.sof_pend | vid_sof_i;
    s_nxt.eof_pend = s_r.eof_pend | vid_eof_i;

    if (reg_wr_i && widx < cvo_pkg::I_FCURL) begin
      s_nxt.regs[widx] = reg_wdata_i;
    end
    if (reg_rd_i) begin
      if (ridx == cvo_pkg::I_FCURL) begin
        s_nxt.rdata = s_r.fnum[7:0];
      end else if (ridx == cvo_pkg::I_FCURH) begin
        s_nxt.rdata = s_r.fnum[15:8];
      end else if (ridx == cvo_pkg::I_NONE) begin
        s_nxt.rdata = '0;
      end else begin
        s_nxt.rdata = s_r.regs[ridx];
      end
    end

    case (s_r.st)
      cvo_pkg::S_IDLE: begin
        s_nxt.hcnt = '0;
        if (s_r.sof_pend) begin
          s_nxt.di = {vc_id_i, cvo_pkg::DT_FS};
          s_nxt.wd = fnext;
          s_nxt.fnum = fnext;
          s_nxt.is_long = 1'b0;
          s_nxt.sof_pend = vid_sof_i;
          s_nxt.st = cvo_pkg::S_HDR;
        end else if (s_r.eof_pend) begin
          s_nxt.di = {vc_id_i, cvo_pkg::DT_FE};
          s_nxt.wd = s_r.fnum;
          s_nxt.is_long = 1'b0;
          s_nxt.eof_pend = vid_eof_i;
          s_nxt.st = cvo_pkg::S_HDR;
        end else if (vid_valid_i) begin
          s_nxt.di = {vc_id_i, cvo_pkg::DT_YUV8};
          s_nxt.wd = {4'h0, wc};
          s_nxt.is_long = 1'b1;
          s_nxt.st = cvo_pkg::S_HDR;
        end
      end
      cvo_pkg::S_HDR: begin
        if (tx_rdy) begin
          s_nxt.byte_d = hb;
          s_nxt.first = (s_r.hcnt == 2'h0);
          s_nxt.last = (s_r.hcnt == 2'h3) && !s_r.is_long;
          s_nxt.req = ~s_r.req;
          s_nxt.hcnt = s_r.hcnt + 2'h1;
          s_nxt.pcnt = '0;
          s_nxt.crc = cvo_pkg::CRC_INIT;
          if (s_r.hcnt == 2'h3) begin
            if (!s_r.is_long) begin
              s_nxt.st = cvo_pkg::S_IDLE;
            end else if (s_r.wd == '0) begin
              s_nxt.st = cvo_pkg::S_CRC;
            end else begin
              s_nxt.st = cvo_pkg::S_PAY;
            end
          end
        end
      end
      cvo_pkg::S_PAY: begin
        s_nxt.hcnt = '0;
        if (tx_rdy && vid_valid_i) begin
          s_nxt.byte_d = vid_data_i;
          s_nxt.first = 1'b0;
          s_nxt.last = 1'b0;
          s_nxt.req = ~s_r.req;
          s_nxt.crc = crc_byte(s_r.crc, vid_data_i);
          s_nxt.pcnt = s_r.pcnt + 12'h001;
          if ({4'h0, s_r.pcnt} == s_r.wd - 16'h0001) begin
            s_nxt.st = cvo_pkg::S_CRC;
          end
        end
      end
      cvo_pkg::S_CRC: begin
        if (tx_rdy) begin
          s_nxt.byte_d = (s_r.hcnt == 2'h0) ? s_r.crc[7:0] : s_r.crc[15:8];
          s_nxt.first = 1'b0;
          s_nxt.last = (s_r.hcnt == 2'h1);
          s_nxt.req = ~s_r.req;
          s_nxt.hcnt = s_r.hcnt + 2'h1;
          if (s_r.hcnt == 2'h1) begin
            s_nxt.st = cvo_pkg::S_IDLE;
          end
        end
      end
      default: begin
        s_nxt.st = cvo_pkg::S_IDLE;
      end
    endcase

    // Soft reset drops the packet in progress; the handshake itself keeps running
    if (hold) begin
      s_nxt.st = cvo_pkg::S_IDLE;
      s_nxt.sof_pend = 1'b0;
      s_nxt.eof_pend = 1'b0;
      s_nxt.hcnt = '0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_r <= '0;
      s_r.regs <= cvo_pkg::REG_RST;
      s_r.st <= cvo_pkg::S_IDLE;
      s_r.crc <= cvo_pkg::CRC_INIT;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Outputs and link config
  // Stream is discarded while held so an upstream decoder never locks up
  assign vid_ready_o        = hold | ((s_r.st == cvo_pkg::S_PAY) & tx_rdy);
  assign reg_rdata_o        = s_r.rdata;
  assign phy_bias_en_o      = s_r.regs[cvo_pkg::I_BIAS][cvo_pkg::B_BIAS];
  assign phy_clk_invert_o   = s_r.regs[cvo_pkg::I_BIAS][cvo_pkg::B_CLK_INV];
  assign lane_clk_mode_en_o = s_r.regs[cvo_pkg::I_CKM][4:0];

  assign lk.req     = s_r.req;
  assign lk.data    = s_r.byte_d;
  assign lk.first   = s_r.first;
  assign lk.last    = s_r.last;
  assign lk.lanes   = lane_count(s_r.regs[cvo_pkg::I_LANE][cvo_pkg::LANE_LSB +: 4]);
  assign lk.sel     = {s_r.regs[cvo_pkg::I_SELC][2:0],
                       s_r.regs[cvo_pkg::I_SEL23][6:4],
                       s_r.regs[cvo_pkg::I_SEL23][2:0],
                       s_r.regs[cvo_pkg::I_SEL01][6:4],
                       s_r.regs[cvo_pkg::I_SEL01][2:0]};
  assign lk.hs_en   = s_r.regs[cvo_pkg::I_HSEN][cvo_pkg::B_HSEN];
  assign lk.ncont   = s_r.regs[cvo_pkg::I_NCONT][cvo_pkg::B_NCONT];
  assign lk.phy_rst = s_r.regs[cvo_pkg::I_RST][cvo_pkg::B_PHY_RST];

  // ==========================================================================
  // Link domain
  cvo_lane_tx u_lane (
    .link_clk_i  (link_clk_i),
    .rst_b_i     (rst_b_i),
    .lk          (lk),
    .lane_data_o (lane_data_o),
    .lane_hs_o   (lane_hs_o)
  );
endmodule
`default_nettype wire
